// ===== verilog/dmrb_pkg.sv
// Package of addresses, field layouts and reset values for the DRAM mode register bank
package dmrb_pkg;

    // ==========================================================
    // Mode register addresses
    localparam logic [5:0] DMRB_ADDR_MAKER = 6'h05;
    localparam logic [5:0] DMRB_ADDR_REV_ONE = 6'h06;
    localparam logic [5:0] DMRB_ADDR_REV_TWO = 6'h07;
    localparam logic [5:0] DMRB_ADDR_DIE_CFG = 6'h08;
    localparam logic [5:0] DMRB_ADDR_VENDOR_TEST = 6'h09;
    localparam logic [5:0] DMRB_ADDR_IMP_RESET = 6'h0A;
    localparam logic [5:0] DMRB_ADDR_TERM = 6'h0B;

    // ==========================================================
    // Die configuration field layout and fixed codes
    localparam int DMRB_CFG_TYPE_LSB = 0;
    localparam int DMRB_CFG_DENS_LSB = 2;
    localparam int DMRB_CFG_WIDTH_LSB = 6;
    localparam logic [1:0] DMRB_TYPE_SIXTEEN_PREFETCH = 2'h0;
    localparam logic [1:0] DMRB_WIDTH_X16 = 2'h0;
    localparam logic [3:0] DMRB_DENS_MAX = 4'h6;

    // ==========================================================
    // Impedance reset and termination field layout
    localparam int DMRB_IMP_DEFAULT_BIT = 0;
    localparam int DMRB_TERM_DATA_LSB = 0;
    localparam int DMRB_TERM_CA_LSB = 4;
    localparam int DMRB_TERM_NT_LO_BIT = 3;
    localparam int DMRB_TERM_NT_HI_BIT = 7;
    localparam logic [2:0] DMRB_TERM_RESERVED = 3'h7;
    localparam logic [2:0] DMRB_TERM_OFF = 3'h0;
    localparam logic [1:0] DMRB_NT_OFF = 2'h0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] DMRB_TERM_RESET = 8'h00;
    localparam logic DMRB_IMP_DEFAULT_RESET = 1'b0;
    localparam logic [7:0] DMRB_VENDOR_TEST_LEGAL = 8'h00;
    localparam logic [7:0] DMRB_READ_ZERO = 8'h00;
    localparam int DMRB_SET_POINTS = 2;

endpackage

// ===== verilog/dmrb_term_bank.sv
// Two set-point copies of the termination word with select-based write access
`timescale 1ns/1ps

module dmrb_term_bank
    import dmrb_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic wr_en, // Write strobe for the selected copy
    input wire logic wr_sel, // Copy chosen for writes and reads
    input wire logic [7:0] wr_data, // Word to store
    input wire logic op_sel, // Copy the device operates from
    output logic [7:0] sel_word, // Copy chosen by the write select
    output logic [7:0] op_word // Copy chosen by the operating select
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [DMRB_SET_POINTS-1:0][7:0] copy;
    } dmrb_bank_t;

    dmrb_bank_t st_q;
    dmrb_bank_t st_d;

    // Only the copy named by the write select changes; the other is untouched
    always_comb
    begin
        st_d = st_q;
        for (int i = 0; i < DMRB_SET_POINTS; i++)
        begin
            if (wr_en && (wr_sel == i[0]))
            begin
                st_d.copy[i] = wr_data;
            end
        end
    end

    // Both copies come out of reset with every termination off
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= {DMRB_SET_POINTS{DMRB_TERM_RESET}};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Read and operating views
    assign sel_word = st_q.copy[wr_sel];
    assign op_word = st_q.copy[op_sel];

endmodule // dmrb_term_bank

// ===== verilog/dmrb_regs.sv
// Mode register bank for identification, impedance reset and termination settings
// Operation
// - Address 05h reads an eight-bit read-only maker identification code.
// - Address 06h reads an eight-bit read-only first revision code.
// - Address 07h reads an eight-bit read-only second revision code.
// - Configuration register 08h, bits 1:0 read 00 for sixteen-word prefetch type.
// - Configuration bits 5:2 give die density, codes 0000 to 0110 valid.
// - Configuration bits 7:6 read 00, meaning sixteen data bits per channel.
// - Register 0Ah bit 0 selects default calibration; zero after reset.
// - Grounded calibration pin forces default calibration and ignores calibration commands.
// - Register 0Bh bits 2:0 set data receiver termination; 111 reserved.
// - Register 0Bh bits 6:4 set command/address termination, same encoding.
// - All termination fields reset to off.
// - Bits 7 and 3 form optional non-target data termination setting.
// - Termination writes and reads touch only the write-select copy.
// - Device operates from the operating-select copy only.
// - Reads drive eight operand bits on data lines, unused bits zero.
`timescale 1ns/1ps

module dmrb_regs
    import dmrb_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] REVISION_ONE = 8'h3C, // Arbitrary value
    parameter logic [7:0] REVISION_TWO = 8'h5A, // Arbitrary value
    parameter logic [3:0] DENSITY_CODE = 4'h2, // Die capacity code
    parameter bit NONTARGET_EN = 1'b1 // Non-target termination fitted
)
(
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic mrw_valid, // Mode register write command
    input wire logic mrr_valid, // Mode register read command
    input wire logic [5:0] mr_addr, // Mode register address
    input wire logic [7:0] mr_wdata, // Write operand
    input wire logic write_set_point_select, // Set point for access
    input wire logic operating_set_point_select, // Set point in use
    input wire logic zq_pin_grounded, // Calibration pin tied to ground
    input wire logic zq_cal_cmd, // Calibration command pulse
    output logic rd_valid, // Read data valid pulse
    output logic [7:0] rd_data, // Read data on lines 7..0
    output logic [2:0] data_rx_termination, // Active data termination
    output logic [2:0] cmd_addr_rx_termination, // Active CA termination
    output logic [1:0] nontarget_data_termination, // Active non-target setting
    output logic impedance_default_apply, // Use default calibration
    output logic zq_cal_start, // Accepted calibration pulse
    output logic vendor_test_bad // Sticky: illegal test write seen
);

    // ==========================================================
    // Reset release
    // Two stages so the release edge never meets a flop mid-cycle
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Decoding helpers
    // Die configuration word assembled from its three fields
    function automatic logic [7:0] cfg_word(input logic [3:0] dens);
        logic [7:0] w;
        w = DMRB_READ_ZERO;
        w[DMRB_CFG_TYPE_LSB +: 2] = DMRB_TYPE_SIXTEEN_PREFETCH;
        w[DMRB_CFG_DENS_LSB +: 4] = dens;
        w[DMRB_CFG_WIDTH_LSB +: 2] = DMRB_WIDTH_X16;
        return w;
    endfunction

    // Termination word as stored, with the optional bits dropped when absent
    function automatic logic [7:0] term_mask(input logic [7:0] w);
        logic [7:0] m;
        m = w;
        if (!NONTARGET_EN)
        begin
            m[DMRB_TERM_NT_HI_BIT] = 1'b0;
            m[DMRB_TERM_NT_LO_BIT] = 1'b0;
        end
        return m;
    endfunction

    // A density code above the top step is reserved; fall back to zero
    localparam logic [3:0] DENS_USED = (DENSITY_CODE > DMRB_DENS_MAX) ? 4'h0 : DENSITY_CODE;

    // ==========================================================
    // Termination storage
    logic term_wr;
    logic [7:0] term_sel_word;
    logic [7:0] term_op_word;

    // Write to the termination address only
    assign term_wr = mrw_valid && (mr_addr == DMRB_ADDR_TERM);

    dmrb_term_bank u_term_bank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(term_wr),
        .wr_sel(write_set_point_select),
        .wr_data(term_mask(mr_wdata)),
        .op_sel(operating_set_point_select),
        .sel_word(term_sel_word),
        .op_word(term_op_word)
    );

    // ==========================================================
    // State
    typedef struct packed {
        logic rd_valid;
        logic [7:0] rd_data;
        logic [2:0] data_term;
        logic [2:0] ca_term;
        logic [1:0] nt_term;
        logic imp_default;
        logic imp_apply;
        logic zq_start;
        logic test_bad;
    } dmrb_state_t;

    dmrb_state_t st_q;
    dmrb_state_t st_d;

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        st_d.zq_start = 1'b0;

        // Impedance reset control: only bit 0 is kept, the rest is reserved
        if (mrw_valid && (mr_addr == DMRB_ADDR_IMP_RESET))
        begin
            st_d.imp_default = mr_wdata[DMRB_IMP_DEFAULT_BIT];
        end

        // Flag any test-register write other than zero; the write itself is dropped
        if (mrw_valid && (mr_addr == DMRB_ADDR_VENDOR_TEST) && (mr_wdata != DMRB_VENDOR_TEST_LEGAL))
        begin
            st_d.test_bad = 1'b1;
        end

        // Identification and configuration have no storage, so writes there
        // fall through without effect

        // Grounded pin overrides the control bit and swallows calibration
        st_d.imp_apply = st_d.imp_default || zq_pin_grounded;
        st_d.zq_start = zq_cal_cmd && !zq_pin_grounded;

        // Operating copy fields drive the receivers
        st_d.data_term = term_op_word[DMRB_TERM_DATA_LSB +: 3];
        st_d.ca_term = term_op_word[DMRB_TERM_CA_LSB +: 3];
        st_d.nt_term = {term_op_word[DMRB_TERM_NT_HI_BIT], term_op_word[DMRB_TERM_NT_LO_BIT]};

        // Reserved receiver code is held but the receiver stays off
        if (st_d.data_term == DMRB_TERM_RESERVED)
        begin
            st_d.data_term = DMRB_TERM_OFF;
        end
        if (st_d.ca_term == DMRB_TERM_RESERVED)
        begin
            st_d.ca_term = DMRB_TERM_OFF;
        end

        // Read answer; a write in the same cycle wins and the read is dropped
        if (mrr_valid && !mrw_valid)
        begin
            st_d.rd_valid = 1'b1;
            unique case (mr_addr)
                DMRB_ADDR_MAKER:
                begin
                    st_d.rd_data = MAKER_CODE;
                end
                DMRB_ADDR_REV_ONE:
                begin
                    st_d.rd_data = REVISION_ONE;
                end
                DMRB_ADDR_REV_TWO:
                begin
                    st_d.rd_data = REVISION_TWO;
                end
                DMRB_ADDR_DIE_CFG:
                begin
                    st_d.rd_data = cfg_word(DENS_USED);
                end
                DMRB_ADDR_TERM:
                begin
                    st_d.rd_data = term_sel_word;
                end
                default:
                begin
                    // Write-only, test and unmapped addresses read as zero
                    st_d.rd_data = DMRB_READ_ZERO;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q.rd_valid <= 1'b0;
            st_q.rd_data <= DMRB_READ_ZERO;
            st_q.data_term <= DMRB_TERM_OFF;
            st_q.ca_term <= DMRB_TERM_OFF;
            st_q.nt_term <= DMRB_NT_OFF;
            st_q.imp_default <= DMRB_IMP_DEFAULT_RESET;
            st_q.imp_apply <= DMRB_IMP_DEFAULT_RESET;
            st_q.zq_start <= 1'b0;
            st_q.test_bad <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs, each straight from a flop
    assign rd_valid = st_q.rd_valid;
    assign rd_data = st_q.rd_data;
    assign data_rx_termination = st_q.data_term;
    assign cmd_addr_rx_termination = st_q.ca_term;
    assign nontarget_data_termination = st_q.nt_term;
    assign impedance_default_apply = st_q.imp_apply;
    assign zq_cal_start = st_q.zq_start;
    assign vendor_test_bad = st_q.test_bad;

endmodule // dmrb_regs

// ===== verification/dmrb_regs_sva.sv
// Checker of the mode register bank port behaviour
`timescale 1ns/1ps

module dmrb_regs_sva
    import dmrb_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] REVISION_ONE = 8'h3C, // Arbitrary value
    parameter logic [7:0] REVISION_TWO = 8'h5A, // Arbitrary value
    parameter logic [3:0] DENSITY_CODE = 4'h2 // Die capacity code
)
(
    input wire logic clk_sys, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic mrw_valid, // Write command
    input wire logic mrr_valid, // Read command
    input wire logic [5:0] mr_addr, // Address
    input wire logic [7:0] mr_wdata, // Operand
    input wire logic zq_pin_grounded, // Pin grounded
    input wire logic zq_cal_cmd, // Calibration command
    input wire logic rd_valid, // Read pulse
    input wire logic [7:0] rd_data, // Read word
    input wire logic [2:0] data_rx_termination, // Data termination
    input wire logic [2:0] cmd_addr_rx_termination, // CA termination
    input wire logic impedance_default_apply, // Default calibration
    input wire logic zq_cal_start, // Calibration accepted
    input wire logic vendor_test_bad // Illegal test write
);
    // ==========================================================
    // A read that collides with a write is dropped, so only lone reads answer
    logic rd_go;
    assign rd_go = mrr_valid && !mrw_valid;
    // A reserved density code reads back as the lowest step
    localparam logic [3:0] DENS_EXP = (DENSITY_CODE > DMRB_DENS_MAX) ? 4'h0 : DENSITY_CODE;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    rd_pulse_a: assert property (rd_go |=> rd_valid) else $error("read not answered");
    no_answer_a: assert property (!rd_go |=> !rd_valid) else $error("stray read answer");
    maker_read_a: assert property (rd_go && mr_addr == DMRB_ADDR_MAKER |=> rd_data == MAKER_CODE)
        else $error("maker code wrong");
    rev_one_a: assert property (rd_go && mr_addr == DMRB_ADDR_REV_ONE |=> rd_data == REVISION_ONE)
        else $error("revision one wrong");
    rev_two_a: assert property (rd_go && mr_addr == DMRB_ADDR_REV_TWO |=> rd_data == REVISION_TWO)
        else $error("revision two wrong");
    die_cfg_a: assert property (rd_go && mr_addr == DMRB_ADDR_DIE_CFG |=>
        rd_data == {DMRB_WIDTH_X16, DENS_EXP, DMRB_TYPE_SIXTEEN_PREFETCH}) else $error("configuration word wrong");
    zq_idle_a: assert property (!zq_cal_cmd |=> !zq_cal_start) else $error("stray calibration start");
    zq_start_a: assert property (zq_cal_cmd |=> zq_cal_start == !$past(zq_pin_grounded))
        else $error("calibration start wrong");
    gnd_default_a: assert property (zq_pin_grounded |=> impedance_default_apply)
        else $error("default calibration missing");
    term_rsvd_a: assert property (data_rx_termination != 3'h7 && cmd_addr_rx_termination != 3'h7)
        else $error("reserved termination applied");
    vendor_bad_a: assert property (mrw_valid && mr_addr == DMRB_ADDR_VENDOR_TEST && mr_wdata != 8'h00
        |=> vendor_test_bad) else $error("illegal test write unflagged");
    // Main scenarios reached
    rd_term_c: cover property (rd_go && mr_addr == DMRB_ADDR_TERM);
    zq_gnd_c: cover property (zq_cal_cmd && zq_pin_grounded);
    vendor_c: cover property ($rose(vendor_test_bad));
    clash_c: cover property (mrw_valid && mrr_valid);
endmodule // dmrb_regs_sva

bind dmrb_regs dmrb_regs_sva #(.MAKER_CODE(MAKER_CODE), .REVISION_ONE(REVISION_ONE),
    .REVISION_TWO(REVISION_TWO), .DENSITY_CODE(DENSITY_CODE)) dmrb_regs_sva_inst (
    .clk_sys(clk_sys), .resetn(resetn), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr),
    .mr_wdata(mr_wdata), .zq_pin_grounded(zq_pin_grounded), .zq_cal_cmd(zq_cal_cmd), .rd_valid(rd_valid),
    .rd_data(rd_data), .data_rx_termination(data_rx_termination),
    .cmd_addr_rx_termination(cmd_addr_rx_termination), .impedance_default_apply(impedance_default_apply),
    .zq_cal_start(zq_cal_start), .vendor_test_bad(vendor_test_bad));

// ===== verification/dmrb_ctrl_model.sv
// Memory controller model issuing mode register commands
`timescale 1ns/1ps

module dmrb_ctrl_model
(
    input wire logic clk_sys, // Clock
    input wire logic rd_valid, // Read pulse
    input wire logic [7:0] rd_data, // Read word
    output logic mrw_valid, // Write command
    output logic mrr_valid, // Read command
    output logic [5:0] mr_addr, // Address
    output logic [7:0] mr_wdata, // Operand
    output logic zq_cal_cmd // Calibration command
);
    // ==========================================================
    // Idle bus at time zero
    initial
    begin
        {mrw_valid, mrr_valid, zq_cal_cmd, mr_addr, mr_wdata} = '0;
    end
    // One-cycle command; released lines show the inverse so stale values never match
    task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic ok,
        output logic [7:0] q);
        @(negedge clk_sys);
        mrw_valid = wr;
        mrr_valid = !wr;
        mr_addr = a;
        mr_wdata = d; // Test register gets 00 unless a scenario breaks it
        @(negedge clk_sys);
        {mrw_valid, mrr_valid} = 2'b00;
        mr_addr = ~a;
        mr_wdata = ~d;
        ok = rd_valid;
        q = rd_data;
    endtask
    // Read and write in one cycle; the write must win and no answer may come
    task automatic clash(input logic [5:0] a, input logic [7:0] d, output logic ok);
        @(negedge clk_sys);
        {mrw_valid, mrr_valid} = 2'b11;
        mr_addr = a;
        mr_wdata = d;
        @(negedge clk_sys);
        {mrw_valid, mrr_valid} = 2'b00;
        mr_addr = ~a;
        mr_wdata = ~d;
        ok = rd_valid;
    endtask
    // Calibration command pulse
    task automatic zq;
        @(negedge clk_sys);
        zq_cal_cmd = 1'b1;
        @(negedge clk_sys);
        zq_cal_cmd = 1'b0;
    endtask
endmodule // dmrb_ctrl_model

// ===== verification/tb_top.sv
// Testbench of the mode register bank
`timescale 1ns/1ps

module tb_top;
    import dmrb_pkg::*;
    localparam logic [7:0] MAKER = 8'h6B; // Arbitrary value
    localparam logic [7:0] REV1 = 8'h17; // Arbitrary value
    localparam logic [7:0] REV2 = 8'h2E; // Arbitrary value
    localparam logic [3:0] DENS = 4'h4;
    logic clk_sys = 1'b0, resetn = 1'b0, ws = 1'b0, os = 1'b0, gnd = 1'b0;
    logic mrw_valid, mrr_valid, zq_cal_cmd, rd_valid, imp, zq_start, bad, ok;
    logic [5:0] mr_addr;
    logic [7:0] mr_wdata, rd_data, q, term_w;
    logic [2:0] dt, ct;
    logic [1:0] nt;
    int n_errors = 0, total_checks = 0, cycles = 0;
    assign term_w = {dt, ct, nt};
    // ==========================================================
    // Clock and hang guard
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            stop_test;
        end
    end
    dmrb_regs #(.MAKER_CODE(MAKER), .REVISION_ONE(REV1), .REVISION_TWO(REV2), .DENSITY_CODE(DENS)) dmrb_regs_inst (
        .clk_sys(clk_sys), .resetn(resetn), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr),
        .mr_wdata(mr_wdata), .write_set_point_select(ws), .operating_set_point_select(os),
        .zq_pin_grounded(gnd), .zq_cal_cmd(zq_cal_cmd), .rd_valid(rd_valid), .rd_data(rd_data),
        .data_rx_termination(dt), .cmd_addr_rx_termination(ct), .nontarget_data_termination(nt),
        .impedance_default_apply(imp), .zq_cal_start(zq_start), .vendor_test_bad(bad));
    dmrb_ctrl_model dmrb_ctrl_model_inst (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
        .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
        .zq_cal_cmd(zq_cal_cmd));
    // ==========================================================
    // Shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        dmrb_ctrl_model_inst.cmd(1'b0, a, 8'h00, ok, q);
        chk({7'h00, ok}, 8'h01);
        chk(q, exp);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        dmrb_ctrl_model_inst.cmd(1'b1, a, d, ok, q);
        chk({7'h00, ok}, 8'h00);
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic do_reset;
        resetn = 1'b0;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_ident;
        rd(DMRB_ADDR_MAKER, MAKER);
        rd(DMRB_ADDR_REV_ONE, REV1);
        rd(DMRB_ADDR_REV_TWO, REV2);
        rd(DMRB_ADDR_DIE_CFG, {2'h0, DENS, 2'h0});
        for (int a = 5; a <= 8; a++)
            wr(a[5:0], 8'hFF);
        rd(DMRB_ADDR_MAKER, MAKER);
        rd(DMRB_ADDR_DIE_CFG, {2'h0, DENS, 2'h0});
        rd(6'h0C, 8'h00);
        $display("identification test done");
    endtask
    task automatic t_imp;
        chk({7'h00, imp}, 8'h00);
        wr(DMRB_ADDR_IMP_RESET, 8'h01);
        chk({7'h00, imp}, 8'h01);
        rd(DMRB_ADDR_IMP_RESET, 8'h00);
        wr(DMRB_ADDR_IMP_RESET, 8'h00);
        chk({7'h00, imp}, 8'h00);
        dmrb_ctrl_model_inst.zq;
        chk({7'h00, zq_start}, 8'h01);
        gnd = 1'b1;
        dmrb_ctrl_model_inst.zq;
        chk({6'h00, zq_start, imp}, 8'h01);
        gnd = 1'b0;
        wr(DMRB_ADDR_VENDOR_TEST, 8'h00);
        chk({7'h00, bad}, 8'h00);
        wr(DMRB_ADDR_VENDOR_TEST, 8'h5A);
        chk({7'h00, bad}, 8'h01);
        rd(DMRB_ADDR_VENDOR_TEST, 8'h00);
        dmrb_ctrl_model_inst.clash(DMRB_ADDR_IMP_RESET, 8'h01, ok);
        chk({7'h00, ok}, 8'h00);
        chk({7'h00, imp}, 8'h01);
        wr(DMRB_ADDR_IMP_RESET, 8'h00);
        chk({7'h00, imp}, 8'h00);
        $display("impedance and test register done");
    endtask
    task automatic t_term;
        chk(term_w, 8'h00);
        wr(DMRB_ADDR_TERM, 8'hA9);
        chk(term_w, {3'h1, 3'h2, 2'h3});
        ws = 1'b1;
        wr(DMRB_ADDR_TERM, 8'h65);
        chk(term_w, {3'h1, 3'h2, 2'h3});
        rd(DMRB_ADDR_TERM, 8'h65);
        ws = 1'b0;
        rd(DMRB_ADDR_TERM, 8'hA9);
        os = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(term_w, {3'h5, 3'h6, 2'h0});
        ws = 1'b1;
        wr(DMRB_ADDR_TERM, 8'h77);
        chk(term_w, 8'h00);
        rd(DMRB_ADDR_TERM, 8'h77);
        do_reset;
        chk(term_w, 8'h00);
        rd(DMRB_ADDR_TERM, 8'h00);
        $display("termination test done");
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        do_reset;
        t_ident;
        t_imp;
        t_term;
        stop_test;
    end
endmodule // tb_top
